// File: tb/remote_line_model.sv
`timescale 1ns/1ps
module remote_line (
  input  wire logic i_clk,
  output logic      o_rx_done,
  output logic [7:0] o_rx_data,
  output logic      o_stop1,
  output logic      o_par_err,
  output logic      o_mpb,
  output logic      o_tx_load,
  output logic      o_tx_last
);
  // ------------------------------------------------------------
  // Line events
  // ------------------------------------------------------------
  initial begin
    {o_rx_done, o_rx_data, o_stop1, o_par_err, o_mpb} = 12'h0;
    {o_tx_load, o_tx_last} = 2'b00;
  end
  // Frame end; only the first stop bit is handed over
  task automatic frame(input logic [7:0] d, input logic s, p, m);
    o_rx_done <= 1'b1;
    {o_rx_data, o_stop1, o_par_err, o_mpb} <= {d, s, p, m};
    @(posedge i_clk);
    o_rx_done <= 1'b0;
    {o_rx_data, o_stop1, o_par_err, o_mpb} <= ~{d, s, p, m};
    @(posedge i_clk);
  endtask
  // Shift register load or last bit sent
  task automatic tx_pulse(input logic last);
    {o_tx_load, o_tx_last} <= {!last, last};
    @(posedge i_clk);
    {o_tx_load, o_tx_last} <= 2'b00;
    @(posedge i_clk);
  endtask
endmodule // remote_line

// File: tb/serial_status_properties.sv
`timescale 1ns/1ps
`include "serial_status_map.vh"
module serial_status_props (
  input logic        I_MCLK,
  input logic        I_RSTN,
  input logic        I_PSEL,
  input logic        I_PENABLE,
  input logic        I_PWRITE,
  input logic [7:0]  I_PADDR,
  input logic [31:0] O_PRDATA,
  input logic        O_PREADY,
  input logic        O_PSLVERR,
  input logic        I_TX_LOAD,
  input logic        I_DTC_TX_WRITE,
  input logic [7:0]  I_DTC_TX_DATA,
  input logic        O_TX_ENABLE,
  input logic        O_TX_EMPTY,
  input logic [7:0]  O_TX_DATA
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  ready_zero_wait_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  slverr_unmapped_a: assert property (O_PREADY && I_PADDR > 8'h0c |-> O_PSLVERR)
    else $error("unmapped access not refused");
  upper_bits_zero_a: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  empty_on_load_a: assert property (I_TX_LOAD && !I_DTC_TX_WRITE |=> O_TX_EMPTY)
    else $error("tx empty not set by load");
  empty_tx_off_a: assert property (!O_TX_ENABLE |=> O_TX_EMPTY)
    else $error("tx empty not held while disabled");
  ctl_write_clr_a: assert property (I_DTC_TX_WRITE && O_TX_ENABLE && !I_TX_LOAD
    |=> !O_TX_EMPTY && O_TX_DATA == $past(I_DTC_TX_DATA))
    else $error("controller write not taken");
  tx_end_flag_tx_off_a: assert property (O_PREADY && !I_PWRITE
    && I_PADDR == `ADDR_STATUS && !$past(O_TX_ENABLE, 1)
    && !$past(O_TX_ENABLE, 2) |-> O_PRDATA[2] && O_PRDATA[7])
    else $error("tx end not held while disabled");
endmodule // serial_status_props
bind serial_status_flags serial_status_props u_props (
  .I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_TX_LOAD(I_TX_LOAD),
  .I_DTC_TX_WRITE(I_DTC_TX_WRITE), .I_DTC_TX_DATA(I_DTC_TX_DATA),
  .O_TX_ENABLE(O_TX_ENABLE), .O_TX_EMPTY(O_TX_EMPTY), .O_TX_DATA(O_TX_DATA));

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "serial_status_map.vh"
module tb_top;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, sync, err;
  logic        dtc_rd, dtc_wr, rx_done, stop1, par_err, rx_multiproc_bit, ld, last;
  logic        tx_en, rx_en, rx_halt, tx_halt, tx_mpb, tx_empty;
  logic [7:0]  paddr, dtc_data, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count;
  int          comparisons;
  serial_status_flags dut (
    .I_MCLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SYNC_MODE(sync),
    .I_RX_DONE(rx_done), .I_RX_DATA(rx_data), .I_RX_STOP1(stop1),
    .I_RX_PAR_ERR(par_err), .I_RX_MPB(rx_multiproc_bit), .I_DTC_RX_READ(dtc_rd),
    .I_TX_LOAD(ld), .I_TX_LAST_BIT(last), .I_DTC_TX_WRITE(dtc_wr),
    .I_DTC_TX_DATA(dtc_data), .O_TX_ENABLE(tx_en), .O_RX_ENABLE(rx_en),
    .O_RX_HALT(rx_halt), .O_TX_HALT(tx_halt), .O_TX_MPB(tx_mpb),
    .O_TX_EMPTY(tx_empty), .O_TX_DATA(tx_data));
  remote_line rmt (
    .i_clk(clk), .o_rx_done(rx_done), .o_rx_data(rx_data), .o_stop1(stop1),
    .o_par_err(par_err), .o_mpb(rx_multiproc_bit), .o_tx_load(ld), .o_tx_last(last));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic pulse_ctl(input logic wr_tx, input logic [7:0] d);
    {dtc_rd, dtc_wr, dtc_data} <= {!wr_tx, wr_tx, d};
    @(posedge clk);
    {dtc_rd, dtc_wr, dtc_data} <= {2'b00, ~d};
    @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rstn, psel, pen, pwr, paddr, pwdata, sync} = 45'h0;
    {dtc_rd, dtc_wr, dtc_data} = 10'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rchk("status", `ADDR_STATUS, 8'h84);
    apb(1'b1, `ADDR_CONTROL, 32'h3);
    rmt.frame(8'ha5, 1'b1, 1'b0, 1'b1);
    rchk("status", `ADDR_STATUS, 8'hc6);
    rchk("rx data", `ADDR_RXDATA, 8'ha5);
    pulse_ctl(1'b0, 8'h00);
    rmt.frame(8'h3c, 1'b0, 1'b0, 1'b0);
    rchk("status", `ADDR_STATUS, 8'h94);
    rchk("rx data", `ADDR_RXDATA, 8'h3c);
    chk("rx halt", 32'h1, {31'h0, rx_halt});
    rmt.frame(8'h55, 1'b1, 1'b0, 1'b1);
    rchk("rx data", `ADDR_RXDATA, 8'h3c);
    apb(1'b1, `ADDR_CONTROL, 32'h1);
    rchk("status", `ADDR_STATUS, 8'h94);
    apb(1'b1, `ADDR_CONTROL, 32'h3);
    apb(1'b1, `ADDR_STATUS, 32'hff);
    rchk("status", `ADDR_STATUS, 8'h95);
    chk("tx mpb", 32'h1, {31'h0, tx_mpb});
    apb(1'b1, `ADDR_STATUS, 32'hff);
    apb(1'b1, `ADDR_STATUS, 32'hef);
    rchk("status", `ADDR_STATUS, 8'h95);
    apb(1'b1, `ADDR_STATUS, 32'hee);
    rchk("status", `ADDR_STATUS, 8'h84);
    rmt.frame(8'h77, 1'b1, 1'b1, 1'b1);
    rchk("status", `ADDR_STATUS, 8'h8e);
    rchk("rx data", `ADDR_RXDATA, 8'h77);
    sync <= 1'b1;
    repeat (2) @(posedge clk);
    chk("tx halt", 32'h1, {31'h0, tx_halt});
    sync <= 1'b0;
    @(posedge clk);
    apb(1'b1, `ADDR_STATUS, 32'hf7);
    rchk("status", `ADDR_STATUS, 8'h87);
    apb(1'b1, `ADDR_STATUS, 32'h7e);
    chk("tx empty", 32'h0, {31'h0, tx_empty});
    rmt.tx_pulse(1'b1);
    rchk("status", `ADDR_STATUS, 8'h02);
    rmt.tx_pulse(1'b0);
    rchk("status", `ADDR_STATUS, 8'h82);
    rmt.tx_pulse(1'b1);
    rchk("status", `ADDR_STATUS, 8'h86);
    pulse_ctl(1'b1, 8'h5a);
    rchk("status", `ADDR_STATUS, 8'h02);
    chk("tx data", 32'h5a, {24'h0, tx_data});
    apb(1'b1, `ADDR_CONTROL, 32'h2);
    rchk("status", `ADDR_STATUS, 8'h86);
    chk("rx enable", 32'h1, {31'h0, rx_en});
    sync <= 1'b1;
    rmt.frame(8'h11, 1'b0, 1'b1, 1'b0);
    sync <= 1'b0;
    rchk("status", `ADDR_STATUS, 8'hc4);
    rchk("unmapped", 8'h20, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rchk("status", `ADDR_STATUS, 8'h84);
    close_out();
  end
endmodule // tb_top

// File: verilog/rx_frame_check.v
`timescale 1ns/1ps
`include "serial_status_map.vh"
module rx_frame_check (
  input  wire i_done,
  input  wire i_enable,
  input  wire i_blocked,
  input  wire i_sync_mode,
  input  wire i_stop1,
  input  wire i_par_err,
  output wire o_accept,
  output wire o_framing,
  output wire o_parity,
  output wire o_normal
);

  // Frames are ignored while disabled or blocked by an error flag
  assign o_accept  = i_done & i_enable & ~i_blocked;
  // Only the first stop bit is looked at
  assign o_framing = o_accept & ~i_sync_mode & ~i_stop1;
  assign o_parity  = o_accept & ~i_sync_mode & i_par_err;
  assign o_normal  = o_accept & ~o_framing & ~o_parity;

endmodule // rx_frame_check

// File: verilog/serial_status_flags.v
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "serial_status_map.vh"
module serial_status_flags (
  input  wire        I_MCLK,
  input  wire        I_RSTN,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire        O_PREADY,
  output wire        O_PSLVERR,
  input  wire        I_SYNC_MODE,
  input  wire        I_RX_DONE,
  input  wire [7:0]  I_RX_DATA,
  input  wire        I_RX_STOP1,
  input  wire        I_RX_PAR_ERR,
  input  wire        I_RX_MPB,
  input  wire        I_DTC_RX_READ,
  input  wire        I_TX_LOAD,
  input  wire        I_TX_LAST_BIT,
  input  wire        I_DTC_TX_WRITE,
  input  wire [7:0]  I_DTC_TX_DATA,
  output wire        O_TX_ENABLE,
  output wire        O_RX_ENABLE,
  output wire        O_RX_HALT,
  output wire        O_TX_HALT,
  output wire        O_TX_MPB,
  output wire        O_TX_EMPTY,
  output wire [7:0]  O_TX_DATA
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg        tx_enable_reg;
  reg        rx_enable_reg;
  reg        tx_end_reg;
  reg        rx_mpb_reg;
  reg        tx_mpb_reg;
  reg [7:0]  rx_buf_reg;
  reg [7:0]  tx_buf_reg;
  reg [31:0] prdata_reg;
  reg        pready_reg;
  reg        pslverr_reg;
  reg        rx_halt_reg;
  reg        tx_halt_reg;

  reg        tx_end_next;
  reg [31:0] rdata_next;
  reg        mapped_next;

  wire       setup_phase;
  wire       access_done;
  wire       wr_done;
  wire       rd_done;
  wire       st_wr;
  wire       st_rd;
  wire [7:0] status_byte;

  wire       framing_flag;
  wire       parity_flag;
  wire       rx_full_flag;
  wire       tx_empty_flag;
  wire       tx_empty_sw_clr;
  wire       rx_accept;
  wire       rx_framing_ev;
  wire       rx_parity_ev;
  wire       rx_normal_ev;
  wire       err_block;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function is_addr;
    input [7:0] addr;
    input [7:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_done = I_PSEL & I_PENABLE & pready_reg;
  assign wr_done     = access_done & I_PWRITE;
  assign rd_done     = access_done & ~I_PWRITE;
  assign st_wr       = wr_done & is_addr(I_PADDR, `ADDR_STATUS);
  assign st_rd       = rd_done & is_addr(I_PADDR, `ADDR_STATUS);
  assign err_block   = framing_flag | parity_flag;

  assign status_byte = {tx_empty_flag, rx_full_flag, `RST_ZERO,
                        framing_flag, parity_flag, tx_end_reg,
                        rx_mpb_reg, tx_mpb_reg};

  // ----------------------------------------------------------------
  // Receive frame checks
  // ----------------------------------------------------------------
  rx_frame_check u_rx_check (
    .i_done      (I_RX_DONE),
    .i_enable    (rx_enable_reg),
    .i_blocked   (err_block),
    .i_sync_mode (I_SYNC_MODE),
    .i_stop1     (I_RX_STOP1),
    .i_par_err   (I_RX_PAR_ERR),
    .o_accept    (rx_accept),
    .o_framing   (rx_framing_ev),
    .o_parity    (rx_parity_ev),
    .o_normal    (rx_normal_ev)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Flags do not watch receive enable once set
  status_clear_flag #(.RESET_VAL(`RST_ZERO)) u_framing (
    .i_clk     (I_MCLK),
    .i_rstn    (I_RSTN),
    .i_set     (rx_framing_ev),
    .i_hw_clr  (`RST_ZERO),
    .i_arm     (st_rd),
    .i_arm_val (prdata_reg[`ST_FRAMING]),
    .i_wr      (st_wr),
    .i_wr_bit  (I_PWDATA[`ST_FRAMING]),
    .o_flag    (framing_flag),
    .o_sw_clr  ()
  );

  status_clear_flag #(.RESET_VAL(`RST_ZERO)) u_parity (
    .i_clk     (I_MCLK),
    .i_rstn    (I_RSTN),
    .i_set     (rx_parity_ev),
    .i_hw_clr  (`RST_ZERO),
    .i_arm     (st_rd),
    .i_arm_val (prdata_reg[`ST_PARITY]),
    .i_wr      (st_wr),
    .i_wr_bit  (I_PWDATA[`ST_PARITY]),
    .o_flag    (parity_flag),
    .o_sw_clr  ()
  );

  status_clear_flag #(.RESET_VAL(`RST_ZERO)) u_rx_full (
    .i_clk     (I_MCLK),
    .i_rstn    (I_RSTN),
    .i_set     (rx_normal_ev),
    .i_hw_clr  (I_DTC_RX_READ),
    .i_arm     (st_rd),
    .i_arm_val (prdata_reg[`ST_RX_FULL]),
    .i_wr      (st_wr),
    .i_wr_bit  (I_PWDATA[`ST_RX_FULL]),
    .o_flag    (rx_full_flag),
    .o_sw_clr  ()
  );

  status_clear_flag #(.RESET_VAL(`RST_ONE)) u_tx_empty (
    .i_clk     (I_MCLK),
    .i_rstn    (I_RSTN),
    .i_set     (~tx_enable_reg | I_TX_LOAD),
    .i_hw_clr  (I_DTC_TX_WRITE),
    .i_arm     (st_rd),
    .i_arm_val (prdata_reg[`ST_TX_EMPTY]),
    .i_wr      (st_wr),
    .i_wr_bit  (I_PWDATA[`ST_TX_EMPTY]),
    .o_flag    (tx_empty_flag),
    .o_sw_clr  (tx_empty_sw_clr)
  );

  // ----------------------------------------------------------------
  // Transmit end
  // ----------------------------------------------------------------
  always @* begin
    tx_end_next = tx_end_reg;
    if (tx_empty_sw_clr) begin
      tx_end_next = `RST_ZERO;
    end
    if (I_DTC_TX_WRITE) begin
      tx_end_next = `RST_ZERO;
    end
    if (!tx_enable_reg) begin
      tx_end_next = `RST_ONE;
    end
    if (I_TX_LAST_BIT & tx_empty_flag) begin
      tx_end_next = `RST_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_next  = `RST_WORD;
    mapped_next = `RST_ONE;
    case (I_PADDR)
      `ADDR_CONTROL: begin
        rdata_next[`CTL_TX_EN] = tx_enable_reg;
        rdata_next[`CTL_RX_EN] = rx_enable_reg;
      end
      `ADDR_STATUS: begin
        rdata_next[7:0] = status_byte;
      end
      `ADDR_RXDATA: begin
        rdata_next[7:0] = rx_buf_reg;
      end
      `ADDR_TXDATA: begin
        rdata_next[7:0] = tx_buf_reg;
      end
      default: begin
        mapped_next = `RST_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prdata_reg  <= `RST_WORD;
      pready_reg  <= `RST_ZERO;
      pslverr_reg <= `RST_ZERO;
    end else begin
      pready_reg <= setup_phase;
      if (setup_phase) begin
        prdata_reg  <= I_PWRITE ? `RST_WORD : rdata_next;
        pslverr_reg <= ~mapped_next;
      end else if (access_done) begin
        pslverr_reg <= `RST_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, data and multiproc bits
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_enable_reg <= `RST_ZERO;
      rx_enable_reg <= `RST_ZERO;
      tx_end_reg    <= `RST_ONE;
      rx_mpb_reg    <= `RST_ZERO;
      tx_mpb_reg    <= `RST_ZERO;
      rx_buf_reg    <= `RST_BYTE;
      tx_buf_reg    <= `RST_BYTE;
      rx_halt_reg   <= `RST_ZERO;
      tx_halt_reg   <= `RST_ZERO;
    end else begin
      tx_end_reg <= tx_end_next;
      if (wr_done & is_addr(I_PADDR, `ADDR_CONTROL)) begin
        tx_enable_reg <= I_PWDATA[`CTL_TX_EN];
        rx_enable_reg <= I_PWDATA[`CTL_RX_EN];
      end
      if (st_wr) begin
        tx_mpb_reg <= I_PWDATA[`ST_TX_MPB];
      end
      if (I_DTC_TX_WRITE) begin
        tx_buf_reg <= I_DTC_TX_DATA;
      end else if (wr_done & is_addr(I_PADDR, `ADDR_TXDATA)) begin
        tx_buf_reg <= I_PWDATA[7:0];
      end
      if (rx_accept) begin
        rx_buf_reg <= I_RX_DATA;
        rx_mpb_reg <= I_RX_MPB;
      end
      rx_halt_reg <= err_block;
      tx_halt_reg <= err_block & I_SYNC_MODE;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_PRDATA    = prdata_reg;
  assign O_PREADY    = pready_reg;
  assign O_PSLVERR   = pslverr_reg;
  assign O_TX_ENABLE = tx_enable_reg;
  assign O_RX_ENABLE = rx_enable_reg;
  assign O_RX_HALT   = rx_halt_reg;
  assign O_TX_HALT   = tx_halt_reg;
  assign O_TX_MPB    = tx_mpb_reg;
  assign O_TX_EMPTY  = tx_empty_flag;
  assign O_TX_DATA   = tx_buf_reg;

endmodule // serial_status_flags

// File: verilog/serial_status_map.vh
`ifndef SERIAL_STATUS_MAP_VH
`define SERIAL_STATUS_MAP_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL   8'h00
`define ADDR_STATUS    8'h04
`define ADDR_RXDATA    8'h08
`define ADDR_TXDATA    8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_TX_EN      0
`define CTL_RX_EN      1
`define ST_TX_EMPTY    7
`define ST_RX_FULL     6
`define ST_FRAMING     4
`define ST_PARITY      3
`define ST_TX_END      2
`define ST_RX_MPB      1
`define ST_TX_MPB      0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ZERO       1'b0
`define RST_ONE        1'b1
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000

`endif

// File: verilog/status_clear_flag.v
`timescale 1ns/1ps
`include "serial_status_map.vh"
module status_clear_flag #(
  parameter RESET_VAL = 1'b0
) (
  input  wire i_clk,
  input  wire i_rstn,
  input  wire i_set,
  input  wire i_hw_clr,
  input  wire i_arm,
  input  wire i_arm_val,
  input  wire i_wr,
  input  wire i_wr_bit,
  output wire o_flag,
  output wire o_sw_clr
);

  reg flag_reg;
  reg arm_reg;
  reg flag_next;
  reg arm_next;

  // Write 0 clears only after the flag was read as 1
  assign o_sw_clr = i_wr & ~i_wr_bit & arm_reg;
  assign o_flag   = flag_reg;

  always @* begin
    flag_next = flag_reg;
    arm_next  = arm_reg;
    if (i_arm) begin
      arm_next = i_arm_val;
    end
    if (i_wr) begin
      arm_next = `RST_ZERO;
    end
    if (o_sw_clr | i_hw_clr) begin
      flag_next = `RST_ZERO;
    end
    // Set wins over a clear in the same cycle
    if (i_set) begin
      flag_next = `RST_ONE;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_reg <= RESET_VAL;
      arm_reg  <= `RST_ZERO;
    end else begin
      flag_reg <= flag_next;
      arm_reg  <= arm_next;
    end
  end

endmodule // status_clear_flag
